// ===== aspbg_pkg.sv
package aspbg_pkg;
    // register word addresses on the apb bus
    localparam logic [7:0] ADDR_BUF = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_TIMER = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    // control register bit positions
    localparam int CTRL_FRAME_W = 7;
    localparam int CTRL_MCE = 5;
    localparam int CTRL_REN = 4;
    localparam int CTRL_TB8 = 3;
    localparam int CTRL_RB8 = 2;
    localparam int CTRL_TXDONE = 1;
    localparam int CTRL_RXDONE = 0;
    // control reads back with bit 6 set
    localparam logic [7:0] CTRL_RESET = 8'h40;
    // timer register layout: [7:0] reload, [10:8] source, [11] run
    localparam int TMR_SRC_LSB = 8;
    localparam int TMR_RUN = 11;
    // timer clock source codes
    localparam logic [2:0] SRC_DIV4 = 3'h0;
    localparam logic [2:0] SRC_DIV12 = 3'h1;
    localparam logic [2:0] SRC_DIV48 = 3'h2;
    localparam logic [2:0] SRC_EXTOSC8 = 3'h3;
    localparam logic [2:0] SRC_EXTPIN = 3'h4;
    // prescale terminal counts
    localparam logic [5:0] DIV4_LAST = 6'h03;
    localparam logic [5:0] DIV12_LAST = 6'h0B;
    localparam logic [5:0] DIV48_LAST = 6'h2F;
    localparam logic [2:0] DIV8_LAST = 3'h7;
    // serial frame lengths (data bits plus ninth)
    localparam logic [3:0] BITS8 = 4'h8;
    localparam logic [3:0] BITS9 = 4'h9;
    // apb signals grouped
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } aspbg_apb_req_t;
endpackage

// ===== aspbg_baud.sv
`timescale 1ns/1ps
// baud timer: tx counter plus hidden rx copy, each divided by two
module aspbg_baud (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // configuration
    input wire logic run_i,
    input wire logic [7:0] reload_i,
    input wire logic [2:0] src_i,
    // synchronised clock sources
    input wire logic extosc_i,
    input wire logic extpin_i,
    // start detected on the receive pin
    input wire logic rx_restart_i,
    // half-bit ticks and bit ticks
    output logic tx_bit_o,
    output logic rx_bit_o,
    output logic rx_half_o
);
    logic [5:0] pre, next_pre;      // core clock prescaler
    logic [2:0] ediv, next_ediv;    // external oscillator divider
    logic eosc_d, epin_d;           // previous levels for edge detect
    logic [7:0] tx_cnt, next_tx_cnt; // visible low count
    logic [7:0] rx_cnt, next_rx_cnt; // hidden receive copy
    logic tx_half, next_tx_half;
    logic rx_ph, next_rx_ph;
    logic tick, tx_ovf, rx_ovf;
    logic eosc_rise;

    // timer input tick from selected source
    always_comb begin
        eosc_rise = extosc_i & ~eosc_d;
        next_pre = pre + 6'h01;
        next_ediv = eosc_rise ? ediv + 3'h1 : ediv;
        tick = 1'b0;
        case (src_i)
            aspbg_pkg::SRC_DIV4: tick = (pre == aspbg_pkg::DIV4_LAST);
            aspbg_pkg::SRC_DIV12: tick = (pre == aspbg_pkg::DIV12_LAST);
            aspbg_pkg::SRC_DIV48: tick = (pre == aspbg_pkg::DIV48_LAST);
            aspbg_pkg::SRC_EXTOSC8: tick = eosc_rise && (ediv == aspbg_pkg::DIV8_LAST);
            aspbg_pkg::SRC_EXTPIN: tick = extpin_i & ~epin_d;
            default: tick = 1'b0;
        endcase
        if (tick || !run_i || src_i > aspbg_pkg::SRC_DIV48) begin
            next_pre = 6'h00;
        end
        // 8-bit auto-reload: overflow then reload; rate = clk/(256-reload)
        tx_ovf = run_i && tick && (tx_cnt == 8'hFF);
        rx_ovf = run_i && tick && (rx_cnt == 8'hFF);
        next_tx_cnt = tx_cnt;
        next_rx_cnt = rx_cnt;
        if (run_i && tick) begin
            next_tx_cnt = tx_ovf ? reload_i : tx_cnt + 8'h01;
            next_rx_cnt = rx_ovf ? reload_i : rx_cnt + 8'h01;
        end
        next_tx_half = tx_ovf ? ~tx_half : tx_half;
        next_rx_ph = rx_ovf ? ~rx_ph : rx_ph;
        // forced reload aligns the receive phase to the start edge
        if (rx_restart_i) begin
            next_rx_cnt = reload_i;
            next_rx_ph = 1'b0;
        end
    end

    // register the timer state
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pre <= 6'h00;
            ediv <= 3'h0;
            eosc_d <= 1'b0;
            epin_d <= 1'b0;
            tx_cnt <= 8'h00;
            rx_cnt <= 8'h00;
            tx_half <= 1'b0;
            rx_ph <= 1'b0;
            tx_bit_o <= 1'b0;
            rx_bit_o <= 1'b0;
            rx_half_o <= 1'b0;
        end else begin
            pre <= next_pre;
            ediv <= next_ediv;
            eosc_d <= extosc_i;
            epin_d <= extpin_i;
            tx_cnt <= next_tx_cnt;
            rx_cnt <= next_rx_cnt;
            tx_half <= next_tx_half;
            rx_ph <= next_rx_ph;
            tx_bit_o <= tx_ovf & tx_half;
            rx_bit_o <= rx_ovf & rx_ph & ~rx_restart_i;
            rx_half_o <= rx_ovf & ~rx_ph & ~rx_restart_i;
        end
    end

    // a tx bit tick is always the second of two overflows
    chk_tx_div_two: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        tx_bit_o |-> $past(tx_half)) else $error("tx bit tick without prior half");
    chk_rx_reload: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        rx_restart_i |=> (rx_cnt == $past(reload_i)) && !rx_ph) else $error("rx timer not reloaded");
endmodule

// ===== aspbg_top.sv
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
// How it works
// - buffer writes transmit, reads give receive
// - interrupt on tx or rx done
// - done flags cleared only by software
// - one received byte buffered during next receive
// - tx timing from 8-bit auto-reload overflows
// - hidden rx timer copy, same reload
// - overflows divided by two per bit
// - start edge forces rx timer reload
// - overflow rate clk over 256 minus reload
// - timer clock: core/4, /12, /48, osc/8, pin
// - only 8-bit and 9-bit framing modes
// - core clock independent of oscillator timer clock
// - start, eight data lsb first, stop
// - ninth bit from tx field, into rx field
// - load only if done clear and check passes
// - tx done set at stop bit start
module aspbg_top (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // apb slave
    input wire aspbg_pkg::aspbg_apb_req_t apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // serial pins and timer clock pins
    input wire logic rx_pin_i,
    input wire logic extosc_i,
    input wire logic timer_ext_input_i,
    output logic tx_pin_o,
    // interrupt
    output logic irq_o
);
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} aspbg_tx_t;
    typedef enum {RX_IDLE, RX_CHECK, RX_DATA, RX_STOP} aspbg_rx_t;

    // two-flop synchronisers for outside inputs
    logic [2:0] sync_a, sync_b;
    logic rx_s, eosc_s, epin_s, rx_prev;

    // control and timer registers
    logic [7:0] ctrl, next_ctrl;
    logic [11:0] tmr, next_tmr;
    logic [1:0] irq_mask, next_irq_mask;
    logic [7:0] rx_buf, next_rx_buf;    // buffered receive data
    // transmit engine
    aspbg_tx_t tx_st, next_tx_st;
    logic [8:0] tx_sh, next_tx_sh;
    logic [3:0] tx_n, next_tx_n;
    logic tx_line, next_tx_line;
    // receive engine
    aspbg_rx_t rx_st, next_rx_st;
    logic [8:0] rx_sh, next_rx_sh;
    logic [3:0] rx_n, next_rx_n;
    // bus outputs
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic next_irq;
    logic acc, wr, rd, buf_wr;
    logic rx_restart, tx_done_set, rx_done_set;
    logic tx_bit, rx_bit, rx_half;
    logic [3:0] nbits;

    // synchroniser stages; first stage only feeds second
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            // rx idles high; clock pins reset low to match the edge detectors
            sync_a <= 3'h1;
            sync_b <= 3'h1;
            rx_prev <= 1'b1;
        end else begin
            sync_a <= {timer_ext_input_i, extosc_i, rx_pin_i};
            sync_b <= sync_a;
            rx_prev <= rx_s;
        end
    end
    assign rx_s = sync_b[0];
    assign eosc_s = sync_b[1];
    assign epin_s = sync_b[2];

    // baud timer; the start edge re-aligns the receive copy
    assign rx_restart = (rx_st == RX_IDLE) && ctrl[aspbg_pkg::CTRL_REN] && rx_prev && !rx_s;
    aspbg_baud u_baud (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .run_i(tmr[aspbg_pkg::TMR_RUN]),
        .reload_i(tmr[7:0]),
        .src_i(tmr[10:8]),
        .extosc_i(eosc_s),
        .extpin_i(epin_s),
        .rx_restart_i(rx_restart),
        .tx_bit_o(tx_bit),
        .rx_bit_o(rx_bit),
        .rx_half_o(rx_half)
    );

    // bus decode; writes land in access, read data is prepared in setup so it stands with pready
    always_comb begin
        acc = apb_i.psel && apb_i.penable;
        wr = acc && apb_i.pwrite;
        rd = apb_i.psel && !apb_i.penable && !apb_i.pwrite;
        buf_wr = wr && (apb_i.paddr == aspbg_pkg::ADDR_BUF);
        // mode bit picks eight or nine bits after start
        nbits = ctrl[aspbg_pkg::CTRL_FRAME_W] ? aspbg_pkg::BITS9 : aspbg_pkg::BITS8;
    end

    // transmit engine next state
    always_comb begin
        next_tx_st = tx_st;
        next_tx_sh = tx_sh;
        next_tx_n = tx_n;
        next_tx_line = tx_line;
        tx_done_set = 1'b0;
        case (tx_st)
            TX_IDLE: begin
                next_tx_line = 1'b1;
                if (buf_wr) begin
                    // ninth bit comes from the software field
                    next_tx_sh = {ctrl[aspbg_pkg::CTRL_TB8], apb_i.pwdata[7:0]};
                    next_tx_st = TX_START;
                end
            end
            TX_START: begin
                // wait for a tx bit boundary, then drive start
                if (tx_bit) begin
                    next_tx_line = 1'b0;
                    next_tx_n = 4'h0;
                    next_tx_st = TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_bit) begin
                    if (tx_n == nbits) begin
                        next_tx_line = 1'b1;            // stop bit
                        tx_done_set = 1'b1;
                        next_tx_st = TX_STOP;
                    end else begin
                        next_tx_line = tx_sh[0];        // lsb first
                        next_tx_sh = {1'b0, tx_sh[8:1]};
                        next_tx_n = tx_n + 4'h1;
                    end
                end
            end
            TX_STOP: begin
                if (buf_wr) begin
                    // done is already set, so the next byte may follow this stop bit
                    next_tx_sh = {ctrl[aspbg_pkg::CTRL_TB8], apb_i.pwdata[7:0]};
                    next_tx_st = TX_START;
                end else if (tx_bit) begin
                    next_tx_st = TX_IDLE;
                end
            end
            default: next_tx_st = TX_IDLE;
        endcase
        // a write while start or data bits shift is ignored
    end

    // receive engine next state
    always_comb begin
        next_rx_st = rx_st;
        next_rx_sh = rx_sh;
        next_rx_n = rx_n;
        rx_done_set = 1'b0;
        next_rx_buf = rx_buf;
        case (rx_st)
            RX_IDLE: begin
                if (rx_restart) begin
                    next_rx_st = RX_CHECK;
                end
            end
            RX_CHECK: begin
                // mid start bit: a high line was a glitch
                if (rx_half) begin
                    next_rx_st = rx_s ? RX_IDLE : RX_DATA;
                    next_rx_n = 4'h0;
                end
            end
            RX_DATA: begin
                // odd overflows after the forced reload fall mid bit
                if (rx_half) begin
                    next_rx_sh = {rx_s, rx_sh[8:1]};
                    next_rx_n = rx_n + 4'h1;
                    if (rx_n + 4'h1 == nbits) begin
                        next_rx_st = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (rx_half) begin
                    next_rx_st = RX_IDLE;
                    // checked bit: stop bit in 8-bit mode, ninth bit in 9-bit mode
                    if (!ctrl[aspbg_pkg::CTRL_RXDONE] &&
                        (!ctrl[aspbg_pkg::CTRL_MCE] ||
                         (ctrl[aspbg_pkg::CTRL_FRAME_W] ? rx_sh[8] : rx_s))) begin
                        rx_done_set = 1'b1;
                        // shifter holds the next byte while this one waits
                        next_rx_buf = ctrl[aspbg_pkg::CTRL_FRAME_W] ? rx_sh[7:0] : rx_sh[8:1];
                    end
                end
            end
            default: next_rx_st = RX_IDLE;
        endcase
    end

    // registers, flags and read data
    always_comb begin
        next_ctrl = ctrl;
        next_tmr = tmr;
        next_irq_mask = irq_mask;
        if (wr && apb_i.paddr == aspbg_pkg::ADDR_CTRL) begin
            // flags only clear by explicit software write
            next_ctrl = {apb_i.pwdata[7], 1'b1, apb_i.pwdata[5:0]};
        end
        if (wr && apb_i.paddr == aspbg_pkg::ADDR_IRQ_STAT) begin
            // write one to clear either done flag
            next_ctrl[1:0] = ctrl[1:0] & ~apb_i.pwdata[1:0];
        end
        if (wr && apb_i.paddr == aspbg_pkg::ADDR_TIMER) begin
            next_tmr = apb_i.pwdata[11:0];
        end
        if (wr && apb_i.paddr == aspbg_pkg::ADDR_IRQ_MASK) begin
            next_irq_mask = apb_i.pwdata[1:0];
        end
        // hardware set wins over a same-cycle clear
        if (tx_done_set) begin
            next_ctrl[aspbg_pkg::CTRL_TXDONE] = 1'b1;
        end
        if (rx_done_set) begin
            next_ctrl[aspbg_pkg::CTRL_RXDONE] = 1'b1;
            next_ctrl[aspbg_pkg::CTRL_RB8] = ctrl[aspbg_pkg::CTRL_FRAME_W] ? rx_sh[8] : rx_s;
        end
        next_irq = |(next_ctrl[1:0] & next_irq_mask);
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (rd) begin
            case (apb_i.paddr)
                aspbg_pkg::ADDR_BUF: next_prdata = {24'h00_0000, rx_buf};
                aspbg_pkg::ADDR_CTRL: next_prdata = {24'h00_0000, ctrl};
                aspbg_pkg::ADDR_TIMER: next_prdata = {20'h0_0000, tmr};
                aspbg_pkg::ADDR_IRQ_STAT: next_prdata = {30'h0000_0000, ctrl[1:0]};
                aspbg_pkg::ADDR_IRQ_MASK: next_prdata = {30'h0000_0000, irq_mask};
                default: next_pslverr = 1'b1;
            endcase
        end else if (apb_i.psel && !apb_i.penable) begin
            next_pslverr = !(apb_i.paddr inside {aspbg_pkg::ADDR_BUF, aspbg_pkg::ADDR_CTRL,
                aspbg_pkg::ADDR_TIMER, aspbg_pkg::ADDR_IRQ_STAT, aspbg_pkg::ADDR_IRQ_MASK});
        end
    end

    // register everything
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ctrl <= aspbg_pkg::CTRL_RESET;
            tmr <= 12'h000;
            irq_mask <= 2'h0;
            rx_buf <= 8'h00;
            tx_st <= TX_IDLE;
            tx_sh <= 9'h000;
            tx_n <= 4'h0;
            tx_line <= 1'b1;
            rx_st <= RX_IDLE;
            rx_sh <= 9'h000;
            rx_n <= 4'h0;
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            tmr <= next_tmr;
            irq_mask <= next_irq_mask;
            rx_buf <= next_rx_buf;
            tx_st <= next_tx_st;
            tx_sh <= next_tx_sh;
            tx_n <= next_tx_n;
            tx_line <= next_tx_line;
            rx_st <= next_rx_st;
            rx_sh <= next_rx_sh;
            rx_n <= next_rx_n;
            prdata_o <= next_prdata;
            pready_o <= apb_i.psel && !apb_i.penable;
            pslverr_o <= next_pslverr;
            irq_o <= next_irq;
        end
    end
    assign tx_pin_o = tx_line;

    chk_irq_follows: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (|(ctrl[1:0] & irq_mask)) |-> irq_o) else $error("irq missing");
    chk_rx_flag_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        ($past(ctrl[0]) && !ctrl[0]) |-> $past(wr)) else $error("rx flag cleared by hardware");
    chk_rx_gate: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        rx_done_set |-> !ctrl[aspbg_pkg::CTRL_RXDONE]) else $error("rx load while flag set");
    chk_tx_stop: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        tx_done_set |=> tx_line && ctrl[1]) else $error("tx done not at stop");
    chk_start_low: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (tx_st == TX_START && tx_bit) |=> !tx_line) else $error("no start bit");
    chk_buf_stable: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !rx_done_set |=> $stable(rx_buf)) else $error("rx buffer changed");
    chk_rx_tick_apart: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        rx_half |-> !rx_bit) else $error("rx mid and edge ticks collide");
endmodule

// ===== aspbg_remote.sv
`timescale 1ns/1ps
// remote asynchronous transceiver facing the serial pins of the block
module aspbg_remote (
    // clock
    input wire logic sys_clk_i,
    // line from the block and line into the block
    input wire logic line_in_i,
    output logic line_out_o
);
    int bit_cyc = 32; // bit time in core clocks, set by the bench
    logic nine = 1'b0; // frames carry a ninth bit
    logic [8:0] got = 9'h000; // last character received
    int got_cnt = 0; // characters received so far

    // the line rests high between frames
    initial line_out_o = 1'b1;

    // send one character: start, data lsb first, optional ninth, stop
    task automatic send(input logic [8:0] ch);
        line_out_o <= 1'b0;
        repeat (bit_cyc) @(posedge sys_clk_i);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            line_out_o <= ch[i];
            repeat (bit_cyc) @(posedge sys_clk_i);
        end
        line_out_o <= 1'b1;
        repeat (bit_cyc) @(posedge sys_clk_i);
    endtask

    // receiver: sample at bit centres; counted only at mid stop bit
    always begin
        @(negedge line_in_i);
        got = 9'h000;
        repeat (bit_cyc / 2) @(posedge sys_clk_i);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (bit_cyc) @(posedge sys_clk_i);
            got[i] = line_in_i;
        end
        repeat (bit_cyc) @(posedge sys_clk_i);
        got_cnt++;
    end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
// bench: apb master, remote transceiver, self checks
module tb;
    logic sys_clk_i = 1'b0; // core clock
    logic srst_i = 1'b1; // sync reset
    aspbg_pkg::aspbg_apb_req_t apb = '0; // apb request
    logic [31:0] prdata; // apb read data
    logic pready, pslverr, rx_line, tx_line, irq; // dut outputs and rx pin
    logic extosc = 1'b0; // oscillator input, period 4 cycles
    logic ext_pin = 1'b0; // timer pin, period 8 cycles
    int num_errors = 0, cmp_count = 0, cycles = 0, old;
    logic [31:0] rd; // last read word
    logic err; // last slave error
    int per_tick[5] = '{4, 12, 48, 32, 8}; // core clocks per timer tick for codes 0..4

    aspbg_top i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .apb_i(apb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .rx_pin_i(rx_line), .extosc_i(extosc),
        .timer_ext_input_i(ext_pin), .tx_pin_o(tx_line), .irq_o(irq));
    aspbg_remote i_remote (.sys_clk_i(sys_clk_i), .line_in_i(tx_line), .line_out_o(rx_line));

    // clock
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // slow clock sources and the hang limit
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        extosc <= cycles[1];
        ext_pin <= cycles[2];
        if (cycles == 60000) begin
            num_errors++;
            $display("unexpected at %0t: timeout", $time);
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one apb transfer; held until pready is sampled high, one idle cycle after
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        apb.psel <= 1'b1;
        apb.pwrite <= wr;
        apb.paddr <= a;
        apb.pwdata <= wd;
        @(posedge sys_clk_i);
        apb.penable <= 1'b1;
        do begin
            @(posedge sys_clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    // poll control until a flag bit is set, bounded
    task automatic wait_flag(input int b);
        int n;
        n = 0;
        do begin
            xfer(1'b0, aspbg_pkg::ADDR_CTRL, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 2000);
        check(32'(rd[b]), 32'h1, "flag wait");
    endtask

    // wait until the remote has taken one more character, bounded
    task automatic wait_remote(input int was);
        int n;
        n = 0;
        while (i_remote.got_cnt == was && n < 5000) begin
            @(posedge sys_clk_i);
            n++;
        end
    endtask

    initial begin
        repeat (2) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        check(32'(tx_line), 32'h1, "tx idle");
        check(32'(irq), 32'h0, "irq reset");
        xfer(1'b0, aspbg_pkg::ADDR_CTRL, 32'h0);
        check(rd, 32'h40, "ctrl reset");
        xfer(1'b1, 8'h20, 32'hFF);
        check(32'(err), 32'h1, "unmapped");
        // transmit one byte from every timer clock source
        for (int s = 0; s < 5; s++) begin
            i_remote.bit_cyc = 2 * (256 - 8'hFC) * per_tick[s];
            xfer(1'b1, aspbg_pkg::ADDR_TIMER, {20'h0, 1'b1, 3'(s), 8'hFC});
            xfer(1'b1, aspbg_pkg::ADDR_IRQ_MASK, (s == 0) ? 32'h0 : 32'h3);
            old = i_remote.got_cnt;
            xfer(1'b1, aspbg_pkg::ADDR_BUF, 32'(8'h5A ^ s));
            wait_flag(aspbg_pkg::CTRL_TXDONE);
            check(32'(tx_line), 32'h1, "stop bit at done");
            check(i_remote.got_cnt, old, "done before stop end");
            @(posedge sys_clk_i);
            check(32'(irq), (s == 0) ? 32'h0 : 32'h1, "irq masking");
            wait_remote(old);
            check(32'(i_remote.got[7:0]), 32'(8'h5A ^ s), "tx byte");
            xfer(1'b0, aspbg_pkg::ADDR_CTRL, 32'h0);
            check(32'(rd[1]), 32'h1, "tx done held");
            xfer(1'b1, aspbg_pkg::ADDR_IRQ_STAT, 32'h2);
            @(posedge sys_clk_i);
            check(32'(irq), 32'h0, "irq cleared");
        end
        // receive in 8-bit framing, second byte starts before first is read
        i_remote.bit_cyc = 32;
        xfer(1'b1, aspbg_pkg::ADDR_TIMER, {20'h0, 1'b1, aspbg_pkg::SRC_DIV4, 8'hFC});
        xfer(1'b1, aspbg_pkg::ADDR_CTRL, 32'h10);
        i_remote.send(9'h03C);
        wait_flag(aspbg_pkg::CTRL_RXDONE);
        check(rd, 32'h55, "ctrl after rx");
        check(32'(irq), 32'h1, "rx irq");
        fork
            i_remote.send(9'h0C3);
            begin
                repeat (96) @(posedge sys_clk_i);
                xfer(1'b0, aspbg_pkg::ADDR_BUF, 32'h0);
                check(rd, 32'h3C, "first byte");
                xfer(1'b1, aspbg_pkg::ADDR_IRQ_STAT, 32'h1);
            end
        join
        wait_flag(aspbg_pkg::CTRL_RXDONE);
        xfer(1'b0, aspbg_pkg::ADDR_BUF, 32'h0);
        check(rd, 32'hC3, "second byte");
        // overrun while the done flag is still set
        i_remote.send(9'h099);
        repeat (40) @(posedge sys_clk_i);
        xfer(1'b0, aspbg_pkg::ADDR_BUF, 32'h0);
        check(rd, 32'hC3, "overrun kept");
        // 9-bit framing with multiprocessor check
        i_remote.nine = 1'b1;
        xfer(1'b1, aspbg_pkg::ADDR_CTRL, 32'hB8);
        old = i_remote.got_cnt;
        xfer(1'b1, aspbg_pkg::ADDR_BUF, 32'h81);
        xfer(1'b0, aspbg_pkg::ADDR_BUF, 32'h0);
        check(rd, 32'hC3, "tx not readable");
        wait_flag(aspbg_pkg::CTRL_TXDONE);
        check(rd, 32'hFA, "ctrl tx9 done");
        wait_remote(old);
        check(32'(i_remote.got), 32'h181, "ninth bit out");
        xfer(1'b1, aspbg_pkg::ADDR_IRQ_STAT, 32'h2);
        i_remote.send(9'h011);
        repeat (40) @(posedge sys_clk_i);
        xfer(1'b0, aspbg_pkg::ADDR_CTRL, 32'h0);
        check(rd, 32'hF8, "data byte ignored");
        i_remote.send(9'h122);
        wait_flag(aspbg_pkg::CTRL_RXDONE);
        check(rd, 32'hFD, "address byte taken");
        xfer(1'b0, aspbg_pkg::ADDR_BUF, 32'h0);
        check(rd, 32'h22, "address data");
        report_and_stop();
    end
endmodule
